/* hw/wts_params.svh */
// constants for the waveform table select and interval block
`ifndef WTS_PARAMS_SVH
`define WTS_PARAMS_SVH
`define WTS_CMD_INTERVAL 8'h50
`define WTS_CMD_SECOND_PLANE 8'h13
`define WTS_BORDER_HI 7
`define WTS_BORDER_LO 6
`define WTS_POL_HI 5
`define WTS_POL_LO 4
`define WTS_CODE_HI 3
`define WTS_CODE_LO 0
`define WTS_RST_BORDER 2'h0
`define WTS_RST_POL 2'h1
`define WTS_RST_CODE 4'h7
`define WTS_INTERVAL_BASE 5'h11
`define WTS_BLANK_TOTAL 5'h14
`endif

/* hw/wts_pkg.sv */
// types for the waveform table select and interval block
package wts_pkg;
  typedef enum logic [7:0] {
    WTS_TBL_FLOAT = 8'h01,
    WTS_TBL_RED = 8'h02,
    WTS_TBL_WHITE = 8'h04,
    WTS_TBL_BLACK = 8'h08,
    WTS_TBL_W2W = 8'h10,
    WTS_TBL_B2W = 8'h20,
    WTS_TBL_W2B = 8'h40,
    WTS_TBL_B2B = 8'h80
  } wts_table_e;
  typedef struct packed {
    logic [1:0] border_table_select;
    logic [1:0] polarity_pair;
    logic [3:0] interval_code;
  } wts_cfg_s;
  typedef enum logic [1:0] {
    WTS_ST_IDLE = 2'h1,
    WTS_ST_PARAM = 2'h2
  } wts_state_e;
endpackage : wts_pkg

/* hw/wts_top.sv */
// command latch and per-pixel table selection for the panel controller
// Overview of operation
// - command 0x50 then byte: border, polarity, interval
// - vcom-to-data gap is 17 minus code
// - back porch up to twenty keeps blanking at twenty; beyond, front porch is zero
// - upper polarity red, lower bw; two-colour lower
// - border code maps to table per mode
// - three-colour: red differs wins, else black/white
// - two-colour new/old pair picks transition table
// - second plane is red or new image
`include "wts_params.svh"
module wts_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // command interface
  input wire logic i_cmd_valid,
  input wire logic i_cmd_is_data,
  input wire logic [7:0] i_cmd_byte,
  // refresh and mode
  input wire logic i_refresh_start,
  input wire logic i_colour_mode_select,
  input wire logic [4:0] i_back_porch,
  // pixel path: plane a is first plane, plane b the second plane
  input wire logic i_pix_valid,
  input wire logic i_pix_plane_a,
  input wire logic i_pix_plane_b,
  // outputs
  output logic [7:0] o_pixel_table,
  output logic o_pixel_valid,
  output logic [7:0] o_border_table,
  output logic [4:0] o_interval_lines,
  output logic [4:0] o_front_porch,
  output logic [7:0] o_active_cfg
);
  wts_pkg::wts_cfg_s pend_ff, nxt_pend;
  wts_pkg::wts_cfg_s act_ff, nxt_act;
  wts_pkg::wts_state_e state_ff, nxt_state;
  logic [7:0] pixel_table_ff;
  logic pixel_valid_ff;
  logic [7:0] border_ff;
  logic [4:0] interval_ff;
  logic [4:0] front_ff;
  logic mode_ff;

  // three-colour: plane b is the red plane, plane a the black/white plane
  function automatic logic [7:0] pick_three(input logic [1:0] pol, input logic a, input logic b);
    logic [7:0] t;
    if (b != pol[1]) begin
      t = wts_pkg::WTS_TBL_RED;
    end else if (a != pol[0]) begin
      t = wts_pkg::WTS_TBL_BLACK;
    end else begin
      t = wts_pkg::WTS_TBL_WHITE;
    end
    return t;
  endfunction

  // two-colour: plane b is the new image, plane a the old one; upper polarity bit unused
  function automatic logic [7:0] pick_two(input logic pol0, input logic a, input logic b);
    logic [7:0] t;
    case ({b ^ pol0, a ^ pol0})
      2'h0: t = wts_pkg::WTS_TBL_W2W;
      2'h1: t = wts_pkg::WTS_TBL_B2W;
      2'h2: t = wts_pkg::WTS_TBL_W2B;
      default: t = wts_pkg::WTS_TBL_B2B;
    endcase
    return t;
  endfunction

  function automatic logic [7:0] pick_border(input logic bw_mode, input logic pol0, input logic [1:0] sel);
    logic [7:0] t;
    logic [1:0] s;
    t = wts_pkg::WTS_TBL_FLOAT;
    s = pol0 ? ~sel : sel;
    if (!bw_mode) begin
      case (s)
        2'h0: t = wts_pkg::WTS_TBL_FLOAT;
        2'h1: t = wts_pkg::WTS_TBL_RED;
        2'h2: t = wts_pkg::WTS_TBL_WHITE;
        default: t = wts_pkg::WTS_TBL_BLACK;
      endcase
    end else begin
      case (s)
        2'h1: t = wts_pkg::WTS_TBL_B2W;
        2'h2: t = wts_pkg::WTS_TBL_W2B;
        default: t = wts_pkg::WTS_TBL_FLOAT;
      endcase
    end
    return t;
  endfunction

  wire armed = (state_ff == wts_pkg::WTS_ST_PARAM);
  wire cmd_hit = i_cmd_valid && !i_cmd_is_data && (i_cmd_byte == `WTS_CMD_INTERVAL);
  wire param_hit = i_cmd_valid && i_cmd_is_data && armed;
  wire [1:0] act_border = act_ff.border_table_select;
  wire [1:0] act_pol = act_ff.polarity_pair;
  wire [3:0] act_code = act_ff.interval_code;
  wire [7:0] nxt_pixel_table = mode_ff ? pick_two(act_pol[0], i_pix_plane_a, i_pix_plane_b)
                               : pick_three(act_pol, i_pix_plane_a, i_pix_plane_b);
  wire [7:0] nxt_border = pick_border(mode_ff, act_pol[0], act_border);
  wire [4:0] nxt_interval = 5'(`WTS_INTERVAL_BASE - {1'b0, act_code});
  // mode is taken only at a refresh boundary, like the settings
  wire nxt_mode = i_refresh_start ? i_colour_mode_select : mode_ff;
  // porch beyond the total clamps the front porch at zero
  wire [4:0] nxt_front = (i_back_porch >= `WTS_BLANK_TOTAL) ? 5'h00
                         : 5'(`WTS_BLANK_TOTAL - i_back_porch);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      wts_pkg::WTS_ST_IDLE: if (cmd_hit) nxt_state = wts_pkg::WTS_ST_PARAM;
      wts_pkg::WTS_ST_PARAM: if (i_cmd_valid) nxt_state = cmd_hit ? wts_pkg::WTS_ST_PARAM : wts_pkg::WTS_ST_IDLE;
      default: nxt_state = wts_pkg::WTS_ST_IDLE;
    endcase
  end

  always_comb begin
    nxt_pend = pend_ff;
    if (param_hit) begin
      nxt_pend.border_table_select = i_cmd_byte[`WTS_BORDER_HI:`WTS_BORDER_LO];
      nxt_pend.polarity_pair = i_cmd_byte[`WTS_POL_HI:`WTS_POL_LO];
      nxt_pend.interval_code = i_cmd_byte[`WTS_CODE_HI:`WTS_CODE_LO];
    end
  end

  // a byte written alongside a refresh start waits for the following refresh
  assign nxt_act = i_refresh_start ? pend_ff : act_ff;

  // command arming
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      state_ff <= wts_pkg::WTS_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // settings from the parameter byte, not yet in use
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pend_ff <= '{`WTS_RST_BORDER, `WTS_RST_POL, `WTS_RST_CODE};
    end else begin
      pend_ff <= nxt_pend;
    end
  end

  // settings in use; a refresh in flight never sees a half-written byte
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      act_ff <= '{`WTS_RST_BORDER, `WTS_RST_POL, `WTS_RST_CODE};
    end else begin
      act_ff <= nxt_act;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      mode_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
    end
  end

  // table index holds between pixels so the panel side sees no glitch
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pixel_table_ff <= 8'h00;
    end else begin
      pixel_table_ff <= i_pix_valid ? nxt_pixel_table : pixel_table_ff;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      pixel_valid_ff <= 1'b0;
    end else begin
      pixel_valid_ff <= i_pix_valid;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      border_ff <= 8'h00;
    end else begin
      border_ff <= nxt_border;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      interval_ff <= 5'h00;
    end else begin
      interval_ff <= nxt_interval;
    end
  end

  // porch follows its input every clock; no refresh gating needed
  always_ff @(posedge i_core_clk) begin
    if (!i_rst_n) begin
      front_ff <= 5'h00;
    end else begin
      front_ff <= nxt_front;
    end
  end

  assign o_pixel_table = pixel_table_ff;
  assign o_pixel_valid = pixel_valid_ff;
  assign o_border_table = border_ff;
  assign o_interval_lines = interval_ff;
  assign o_front_porch = front_ff;
  assign o_active_cfg = act_ff;
endmodule // wts_top

/* dv/wts_host.sv */
// host model writing command bytes
module wts_host (
  input wire logic i_clk,
  output logic o_v = 1'b0,
  output logic o_d = 1'b0,
  output logic [7:0] o_b = 8'h00
);
  timeunit 1ns / 1ps;
  // idle bus shows the inverse byte so stale data is never taken
  task automatic send(input logic d, input logic [7:0] b);
    @(posedge i_clk);
    o_v <= 1'b1;
    o_d <= d;
    o_b <= b;
    @(posedge i_clk);
    o_v <= 1'b0;
    o_b <= ~b;
  endtask
endmodule // wts_host

/* dv/wts_top_props.sv */
// checker for wts_top
module wts_top_chk (
  input wire logic i_core_clk, i_rst_n, i_refresh_start, i_colour_mode_select, i_pix_valid, o_pixel_valid,
  input wire logic [7:0] o_pixel_table, o_border_table, o_active_cfg,
  input wire logic [4:0] i_back_porch, o_interval_lines, o_front_porch
);
  logic live_ff, mode_ff;
  logic [1:0] sel;
  logic [7:0] bexp;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!(live_ff & i_rst_n));
  assign sel = o_active_cfg[4] ? ~o_active_cfg[7:6] : o_active_cfg[7:6];
  assign bexp = !mode_ff ? 8'h01 << sel : sel == 2'h1 ? 8'h20 : sel == 2'h2 ? 8'h40 : 8'h01;
  always_ff @(posedge i_core_clk) begin
    live_ff <= i_rst_n;
    mode_ff <= i_rst_n & (i_refresh_start ? i_colour_mode_select : mode_ff);
  end
  a_gap_lines: assert property (o_interval_lines == 5'h11 - $past(o_active_cfg[3:0])) else $error("gap");
  a_blank_total: assert property (o_front_porch == ($past(i_back_porch) > 5'h13 ? 5'h00 : 5'h14 - $past(i_back_porch)))
    else $error("porch");
  a_border_map: assert property (o_border_table == $past(bexp)) else $error("border");
  a_cfg_hold: assert property (!$past(i_refresh_start) |-> $stable(o_active_cfg)) else $error("cfg");
  a_pix_pulse: assert property (o_pixel_valid == $past(i_pix_valid)) else $error("pulse");
  a_pix_hold: assert property (!i_pix_valid |=> $stable(o_pixel_table)) else $error("hold");
  a_pix_onehot: assert property (o_pixel_valid |-> $onehot(o_pixel_table)) else $error("onehot");
  a_two_colour: assert property (o_pixel_valid & $past(mode_ff) |-> o_pixel_table > 8'h08) else $error("two");
  cover property (i_refresh_start & i_colour_mode_select);
  cover property (o_pixel_valid & !mode_ff);
  cover property (o_pixel_valid & mode_ff);
endmodule // wts_top_chk
bind wts_top wts_top_chk i_chk (
  .i_core_clk(i_core_clk),
  .i_rst_n(i_rst_n),
  .i_refresh_start(i_refresh_start),
  .i_colour_mode_select(i_colour_mode_select),
  .i_pix_valid(i_pix_valid),
  .o_pixel_valid(o_pixel_valid),
  .o_pixel_table(o_pixel_table),
  .o_border_table(o_border_table),
  .o_active_cfg(o_active_cfg),
  .i_back_porch(i_back_porch),
  .o_interval_lines(o_interval_lines),
  .o_front_porch(o_front_porch)
);

/* dv/tb_wts_top.sv */
// self-checking bench for wts_top
module tb_wts_top;
  timeunit 1ns / 1ps;
  logic i_core_clk = 1'b0, i_rst_n = 1'b0, i_refresh_start = 1'b0, i_colour_mode_select = 1'b0;
  logic i_pix_valid = 1'b0, i_pix_plane_a = 1'b0, i_pix_plane_b = 1'b0, i_cmd_valid, i_cmd_is_data, o_pixel_valid;
  logic [7:0] i_cmd_byte, o_pixel_table, o_border_table, o_active_cfg, c, q[$];
  logic [4:0] i_back_porch = 5'h00, o_interval_lines, o_front_porch;
  logic [31:0] r = 32'hE108;
  int fail_count = 0, total_checks = 0;
  always #5 i_core_clk = ~i_core_clk;
  wts_host i_host (.i_clk(i_core_clk), .o_v(i_cmd_valid), .o_d(i_cmd_is_data), .o_b(i_cmd_byte));
  wts_top i_dut (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_cmd_valid(i_cmd_valid),
    .i_cmd_is_data(i_cmd_is_data),
    .i_cmd_byte(i_cmd_byte),
    .i_refresh_start(i_refresh_start),
    .i_colour_mode_select(i_colour_mode_select),
    .i_back_porch(i_back_porch),
    .i_pix_valid(i_pix_valid),
    .i_pix_plane_a(i_pix_plane_a),
    .i_pix_plane_b(i_pix_plane_b),
    .o_pixel_table(o_pixel_table),
    .o_pixel_valid(o_pixel_valid),
    .o_border_table(o_border_table),
    .o_interval_lines(o_interval_lines),
    .o_front_porch(o_front_porch),
    .o_active_cfg(o_active_cfg)
  );
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s;
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // border table per mode, lower polarity bit and select code
  function automatic logic [7:0] exp_border(input logic bw, input logic [7:0] cfg);
    logic [7:0] t;
    case ({bw, cfg[4], cfg[7:6]})
      4'h1: t = 8'h02;
      4'h2: t = 8'h04;
      4'h3: t = 8'h08;
      4'h4: t = 8'h08;
      4'h5: t = 8'h04;
      4'h6: t = 8'h02;
      4'h9: t = 8'h20;
      4'hA: t = 8'h40;
      4'hD: t = 8'h40;
      4'hE: t = 8'h20;
      default: t = 8'h01;
    endcase
    return t;
  endfunction
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // results are looked at mid-cycle, where the registered outputs have settled
  always @(negedge i_core_clk) begin
    if (o_pixel_valid === 1'b1) begin
      if (q.size() == 0) begin
        fail_count++;
        $display("[FAIL] %0t pixel result with no note", $time);
      end else begin
        chk(o_pixel_table, q.pop_front());
      end
    end
  end
  initial begin
    #40us;
    fail_count++;
    results;
  end
  initial begin
    repeat (4) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 32; k++) begin
      c = {k[1:0], k[3:2], k[3:0]};
      i_host.send(1'b0, 8'h50);
      i_host.send(1'b1, c);
      // unarmed byte must be ignored
      i_host.send(1'b1, ~c);
      @(posedge i_core_clk);
      i_refresh_start <= 1'b1;
      i_colour_mode_select <= k[4];
      @(posedge i_core_clk);
      i_refresh_start <= 1'b0;
      i_colour_mode_select <= !k[4];
      repeat (3) @(posedge i_core_clk);
      @(negedge i_core_clk);
      chk(o_active_cfg, c);
      chk(o_border_table, exp_border(k[4], c));
      chk({3'h0, o_interval_lines}, 8'h11 - {4'h0, c[3:0]});
      chk({3'h0, o_front_porch}, (i_back_porch >= 5'h14) ? 8'h00 : 8'h14 - {3'h0, i_back_porch});
      repeat (8) begin
        @(posedge i_core_clk);
        r = xorshift(r);
        {i_back_porch, i_pix_plane_b, i_pix_plane_a, i_pix_valid} <= r[7:0];
        if (r[0]) q.push_back(k[4] ? 8'h10 << {r[2] ^ c[4], r[1] ^ c[4]} :
          r[2] != c[5] ? 8'h02 : r[1] != c[4] ? 8'h08 : 8'h04);
      end
      @(posedge i_core_clk);
      i_pix_valid <= 1'b0;
      $display("test %0d done", k);
    end
    repeat (2) @(posedge i_core_clk);
    if (q.size() != 0) begin
      fail_count++;
      $display("[FAIL] %0t pixel notes left unanswered", $time);
    end
    results;
  end
endmodule // tb_wts_top
